// ---- logic/servo_drive_config_decode.sv ----
// Servo drive configuration decode: parameter table, pin sampling,
// alarm, stop sequencing, reference decode and error counter.
// Assumes parameter access and internal status from clk_sys logic;
// sequence and reference pins arrive asynchronously.
//
// Function
// - Servo-on input gates drive when its use setting is 0, else ignored.
// - Forward inhibit input is honoured at setting 0, ignored at 1.
// - Reverse inhibit input is honoured at setting 0, ignored at 1.
// - Power recovery clears the alarm at setting 0, keeps it at 1.
// - Stop method 0 brakes dynamically then releases, 1 coasts.
// - Methods 2 and 3 plug-brake on overtravel then disable.
// - Methods 4 and 5 plug-brake on overtravel then zero clamp.
// - Error counter clears on entering disable at setting 0 only.
// - Rotation sense 0 makes forward CCW, 1 makes forward CW.
// - Analog speed limit applies only at setting 1.
// - Reference pulses decode per the five pulse formats.
// - Pulse and direction lines may each be inverted first.
// - Analog current limit is off at setting 0.
`timescale 1ns/10ps
`default_nettype none
`include "servo_cfg_params.svh"

module servo_drive_config_decode
#(
	parameter int ERR_W = 32
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,

	// Parameter access
	input wire logic param_wr_en,
	input wire logic [3:0] param_sel,
	input wire logic [15:0] param_wdata,
	output logic [15:0] param_rdata,
	output logic param_wr_err,

	// Sequence input pins
	input wire logic servo_on_in_b,
	input wire logic fwd_travel_inhibit,
	input wire logic rev_travel_inhibit,
	input wire logic alarm_reset_in,
	input wire logic power_loss_in,

	// Reference pulse pins
	input wire logic pulse_input,
	input wire logic direction_input,

	// Internal status, same clock
	input wire logic fault_in,
	input wire logic motor_stopped,
	input wire logic fb_step,
	input wire logic fb_fwd,

	// Drive control
	output logic drive_enable,
	output logic dynamic_braking,
	output logic plug_braking,
	output logic zero_clamp,
	output logic servo_disabled_state,
	output logic servo_alarm_output,

	// Reference and position
	output logic ref_step,
	output logic ref_ccw,
	output logic [ERR_W-1:0] err_count,

	// Analog limit enables
	output logic speed_limit_en,
	output logic current_limit_en
);

	//----------------------------------------------------------------
	// Parameter table
	//----------------------------------------------------------------

	servo_cfg_pkg::cfg_word_t cfg_reg [0:`CFG_NUM-1];
	logic [15:0] param_rdata_next;
	logic sel_ok;
	logic val_ok;

	// Largest legal value of each parameter
	function automatic servo_cfg_pkg::cfg_word_t cfg_max(
		input logic [3:0] idx);
		servo_cfg_pkg::cfg_word_t m;
		m = `MAX_BINARY;
		case (idx)
			`IDX_STOP_METHOD:
				m = `MAX_STOP;
			`IDX_PULSE_FMT:
				m = `MAX_FMT;
			`IDX_PULSE_POL:
				m = `MAX_POL;
			default:
				m = `MAX_BINARY;
		endcase
		return m;
	endfunction : cfg_max

	// Out-of-range settings are refused so decode never sees them
	assign sel_ok = (param_sel < 4'(`CFG_NUM));
	assign val_ok = (param_wdata <= cfg_max(param_sel));

	// One storage word per parameter
	genvar gi;
	generate
		for (gi = 0; gi < `CFG_NUM; gi++)
		begin : g_cfg
			always_ff @(posedge clk_sys or negedge rst_b)
			begin
				if (!rst_b)
					cfg_reg[gi] <= `CFG_RST;
				else if (param_wr_en && val_ok
					&& param_sel == 4'(gi))
					cfg_reg[gi] <= param_wdata;
			end
		end
	endgenerate

	// Read-back mux, zero past the table
	always_comb
	begin
		param_rdata_next = 16'h0000;
		if (sel_ok)
			param_rdata_next = cfg_reg[param_sel];
	end

	// Registered read data
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			param_rdata <= 16'h0000;
		else
			param_rdata <= param_rdata_next;
	end

	// Refused write flag, one cycle
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			param_wr_err <= 1'b0;
		else
			param_wr_err <= param_wr_en && !(sel_ok && val_ok);
	end

	//----------------------------------------------------------------
	// Pin synchronisers
	//----------------------------------------------------------------

	localparam int SYNC_N = 7;
	localparam logic [SYNC_N-1:0] SYNC_RST = `SYNC_RST;

	logic [SYNC_N-1:0] pin_raw;
	logic [SYNC_N-1:0] meta_reg;
	logic [SYNC_N-1:0] sync_reg;

	assign pin_raw = {servo_on_in_b, fwd_travel_inhibit,
		rev_travel_inhibit, alarm_reset_in, power_loss_in,
		pulse_input, direction_input};

	// Two flops per pin; servo-on resets to the off level
	genvar si;
	generate
		for (si = 0; si < SYNC_N; si++)
		begin : g_sync
			always_ff @(posedge clk_sys or negedge rst_b)
			begin
				if (!rst_b)
				begin
					meta_reg[si] <= SYNC_RST[si];
					sync_reg[si] <= SYNC_RST[si];
				end
				else
				begin
					meta_reg[si] <= pin_raw[si];
					sync_reg[si] <= meta_reg[si];
				end
			end
		end
	endgenerate

	logic son_b_s;
	logic fwd_inh_s;
	logic rev_inh_s;
	logic alm_rst_s;
	logic pwr_loss_s;
	logic pulse_s;
	logic dir_s;

	assign {son_b_s, fwd_inh_s, rev_inh_s, alm_rst_s, pwr_loss_s,
		pulse_s, dir_s} = sync_reg;

	// Previous levels for edge detection
	logic alm_rst_d_reg;
	logic pwr_loss_d_reg;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			alm_rst_d_reg <= 1'b0;
			pwr_loss_d_reg <= 1'b0;
		end
		else
		begin
			alm_rst_d_reg <= alm_rst_s;
			pwr_loss_d_reg <= pwr_loss_s;
		end
	end

	//----------------------------------------------------------------
	// Alarm
	//----------------------------------------------------------------

	logic alm_set;
	logic alm_clr;
	logic pwr_recover;

	assign pwr_recover = pwr_loss_d_reg & ~pwr_loss_s;
	// A power dip raises the alarm like any other fault
	assign alm_set = fault_in | (pwr_loss_s & ~pwr_loss_d_reg);
	assign alm_clr = (alm_rst_s & ~alm_rst_d_reg)
		| (pwr_recover
		&& cfg_reg[`IDX_PWR_LOSS_RCV] == `CFG_RST);

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			servo_alarm_output <= 1'b0;
		else if (alm_set)
			servo_alarm_output <= 1'b1;
		else if (alm_clr)
			servo_alarm_output <= 1'b0;
	end

	//----------------------------------------------------------------
	// Stop causes and sequencing
	//----------------------------------------------------------------

	logic son_used;
	logic servo_off;
	logic fwd_ot;
	logic rev_ot;
	logic overtravel;

	assign son_used = (cfg_reg[`IDX_SERVO_EN_USE] == `CFG_RST);
	// Input high means servo off; alarm and power dip also stop
	assign servo_off = (son_used & son_b_s) | servo_alarm_output
		| pwr_loss_s;
	assign fwd_ot = fwd_inh_s
		&& cfg_reg[`IDX_FWD_INH_USE] == `CFG_RST;
	assign rev_ot = rev_inh_s
		&& cfg_reg[`IDX_REV_INH_USE] == `CFG_RST;
	assign overtravel = fwd_ot | rev_ot;

	servo_cfg_pkg::stop_state_t stop_state;
	logic off_entry;

	stop_sequencer u_stop
	(
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.method(cfg_reg[`IDX_STOP_METHOD][2:0]),
		.servo_off(servo_off),
		.overtravel(overtravel),
		.motor_stopped(motor_stopped),
		.state(stop_state),
		.off_entry(off_entry)
	);

	// Drive control outputs decoded from the stop state
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			drive_enable <= 1'b0;
			dynamic_braking <= 1'b0;
			plug_braking <= 1'b0;
			zero_clamp <= 1'b0;
			servo_disabled_state <= 1'b1;
		end
		else
		begin
			drive_enable <= (stop_state == servo_cfg_pkg::ST_RUN)
				|| (stop_state == servo_cfg_pkg::ST_PLUG)
				|| (stop_state == servo_cfg_pkg::ST_CLAMP);
			dynamic_braking <= (stop_state == servo_cfg_pkg::ST_DB);
			plug_braking <= (stop_state == servo_cfg_pkg::ST_PLUG);
			zero_clamp <= (stop_state == servo_cfg_pkg::ST_CLAMP);
			servo_disabled_state <= (stop_state == servo_cfg_pkg::ST_OFF);
		end
	end

	//----------------------------------------------------------------
	// Reference decode
	//----------------------------------------------------------------

	logic dec_step;
	logic dec_fwd;

	// Host must match lines to format and polarity
	pulse_ref_decoder u_dec
	(
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.fmt(cfg_reg[`IDX_PULSE_FMT][2:0]),
		.pol(cfg_reg[`IDX_PULSE_POL][1:0]),
		.pulse_s(pulse_s),
		.dir_s(dir_s),
		.step(dec_step),
		.step_fwd(dec_fwd)
	);

	// Forward maps to CCW unless reverse rotation mode is set
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ref_step <= 1'b0;
			ref_ccw <= 1'b0;
		end
		else
		begin
			ref_step <= dec_step;
			ref_ccw <= dec_fwd ^ cfg_reg[`IDX_ROT_SENSE][0];
		end
	end

	//----------------------------------------------------------------
	// Position error counter
	//----------------------------------------------------------------

	logic [1:0] up_cnt;
	logic [1:0] dn_cnt;
	logic [ERR_W-1:0] err_next;

	// Reference adds, feedback subtracts; both may land together
	always_comb
	begin
		up_cnt = {1'b0, dec_step & dec_fwd}
			+ {1'b0, fb_step & ~fb_fwd};
		dn_cnt = {1'b0, dec_step & ~dec_fwd}
			+ {1'b0, fb_step & fb_fwd};
		err_next = err_count + ERR_W'(up_cnt) - ERR_W'(dn_cnt);
	end

	// Clear on disable entry drops that cycle's counts too
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			err_count <= '0;
		else if (off_entry
			&& cfg_reg[`IDX_ERR_CLR] == `CFG_RST)
			err_count <= '0;
		else
			err_count <= err_next;
	end

	//----------------------------------------------------------------
	// Analog limit enables
	//----------------------------------------------------------------

	// Registered so the analog path sees a clean level
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			speed_limit_en <= 1'b0;
			current_limit_en <= 1'b0;
		end
		else
		begin
			speed_limit_en <= cfg_reg[`IDX_SPD_LIM_USE][0];
			current_limit_en <= cfg_reg[`IDX_CUR_LIM_USE][0];
		end
	end

endmodule : servo_drive_config_decode
`default_nettype wire

// ---- logic/servo_cfg_params.svh ----
// Constants for the servo drive configuration decode block.
// Assumes inclusion by bare name from files under logic/.
`ifndef SERVO_CFG_PARAMS_SVH
`define SERVO_CFG_PARAMS_SVH

// Parameter table geometry
`define CFG_NUM 11
`define CFG_W 16
`define CFG_RST 16'h0000

// Parameter numbers, used as the select index
`define IDX_SERVO_EN_USE 4'h0
`define IDX_FWD_INH_USE 4'h1
`define IDX_REV_INH_USE 4'h2
`define IDX_PWR_LOSS_RCV 4'h3
`define IDX_STOP_METHOD 4'h4
`define IDX_ERR_CLR 4'h5
`define IDX_ROT_SENSE 4'h6
`define IDX_SPD_LIM_USE 4'h7
`define IDX_PULSE_FMT 4'h8
`define IDX_PULSE_POL 4'h9
`define IDX_CUR_LIM_USE 4'hA

// Largest legal setting per parameter kind
`define MAX_BINARY 16'h0001
`define MAX_STOP 16'h0005
`define MAX_FMT 16'h0004
`define MAX_POL 16'h0003

// Reference pulse formats
`define FMT_SIGN_PULSE 3'h0
`define FMT_CW_CCW 3'h1
`define FMT_AB_X1 3'h2
`define FMT_AB_X2 3'h3
`define FMT_AB_X4 3'h4

// Polarity field bits
`define POL_DIR_BIT 0
`define POL_PULSE_BIT 1

// Reset levels of the synchronised pins, MSB first
`define SYNC_RST 7'h40

`endif

// ---- logic/servo_cfg_pkg.sv ----
// Types shared by the configuration decode block.
// Assumes nothing of its surroundings.
package servo_cfg_pkg;

	// Stop sequencer states
	typedef enum logic [2:0]
	{
		ST_RUN = 3'b000,
		ST_DB = 3'b001,
		ST_COAST = 3'b010,
		ST_PLUG = 3'b011,
		ST_CLAMP = 3'b100,
		ST_OFF = 3'b101
	} stop_state_t;

	typedef logic [15:0] cfg_word_t;

endpackage : servo_cfg_pkg

// ---- logic/pulse_ref_decoder.sv ----
// Reference pulse decoder: polarity, then format decode to steps.
// Assumes both inputs already synchronised to clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "servo_cfg_params.svh"

module pulse_ref_decoder
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Settings
	input wire logic [2:0] fmt,
	input wire logic [1:0] pol,
	// Synchronised lines
	input wire logic pulse_s,
	input wire logic dir_s,
	// Decoded step
	output logic step,
	output logic step_fwd
);

	logic a;
	logic b;
	logic a_reg;
	logic b_reg;
	logic step_next;
	logic fwd_next;

	// Optional inversion ahead of decoding
	assign a = pulse_s ^ pol[`POL_PULSE_BIT];
	assign b = dir_s ^ pol[`POL_DIR_BIT];

	// Previous line levels for edge detection
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			a_reg <= 1'b0;
			b_reg <= 1'b0;
		end
		else
		begin
			a_reg <= a;
			b_reg <= b;
		end
	end

	// Format decode; quadrature sense is A leading B forward
	always_comb
	begin
		step_next = 1'b0;
		fwd_next = 1'b0;
		case (fmt)
			`FMT_SIGN_PULSE:
			begin
				step_next = a & ~a_reg;
				fwd_next = b;
			end
			`FMT_CW_CCW:
			begin
				step_next = (a & ~a_reg) | (b & ~b_reg);
				fwd_next = a & ~a_reg;
			end
			`FMT_AB_X1:
			begin
				step_next = a & ~a_reg;
				fwd_next = ~b;
			end
			`FMT_AB_X2:
			begin
				step_next = a ^ a_reg;
				fwd_next = a ^ b;
			end
			`FMT_AB_X4:
			begin
				step_next = (a ^ a_reg) | (b ^ b_reg);
				fwd_next = a ^ b_reg;
			end
			default:
			begin
				step_next = 1'b0;
				fwd_next = 1'b0;
			end
		endcase
	end

	// Registered step outputs
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			step <= 1'b0;
			step_fwd <= 1'b0;
		end
		else
		begin
			step <= step_next;
			step_fwd <= fwd_next;
		end
	end

endmodule : pulse_ref_decoder
`default_nettype wire

// ---- logic/stop_sequencer.sv ----
// Stop sequencer: picks braking per stop method and stop cause.
// Assumes cause and stop inputs are synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none

module stop_sequencer
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Setting
	input wire logic [2:0] method,
	// Causes and motion state
	input wire logic servo_off,
	input wire logic overtravel,
	input wire logic motor_stopped,
	// State
	output servo_cfg_pkg::stop_state_t state,
	output logic off_entry
);

	servo_cfg_pkg::stop_state_t state_next;
	logic off_brake;
	logic plug_ot;

	// Even methods brake on servo-off, odd ones coast
	assign off_brake = ~method[0];
	// Methods from two upward plug-brake on overtravel
	assign plug_ot = (method >= 3'h2);

	always_comb
	begin
		state_next = state;
		case (state)
			servo_cfg_pkg::ST_RUN, servo_cfg_pkg::ST_CLAMP:
			begin
				if (overtravel && plug_ot && state == servo_cfg_pkg::ST_RUN)
					state_next = servo_cfg_pkg::ST_PLUG;
				else if (servo_off || (overtravel && !plug_ot))
					state_next = off_brake ? servo_cfg_pkg::ST_DB
						: servo_cfg_pkg::ST_COAST;
				else if (state == servo_cfg_pkg::ST_CLAMP && !overtravel)
					state_next = servo_cfg_pkg::ST_RUN;
			end
			servo_cfg_pkg::ST_DB, servo_cfg_pkg::ST_COAST:
			begin
				// Brake released once still
				if (motor_stopped)
					state_next = servo_cfg_pkg::ST_OFF;
			end
			servo_cfg_pkg::ST_PLUG:
			begin
				if (servo_off)
					state_next = off_brake ? servo_cfg_pkg::ST_DB
						: servo_cfg_pkg::ST_COAST;
				else if (motor_stopped)
					state_next = method[2] ? servo_cfg_pkg::ST_CLAMP
						: servo_cfg_pkg::ST_OFF;
			end
			servo_cfg_pkg::ST_OFF:
			begin
				if (!servo_off && !overtravel)
					state_next = servo_cfg_pkg::ST_RUN;
			end
			default:
				state_next = servo_cfg_pkg::ST_OFF;
		endcase
	end

	// State register and disable-entry pulse
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= servo_cfg_pkg::ST_OFF;
			off_entry <= 1'b0;
		end
		else
		begin
			state <= state_next;
			off_entry <= (state_next == servo_cfg_pkg::ST_OFF)
				&& (state != servo_cfg_pkg::ST_OFF);
		end
	end

endmodule : stop_sequencer
`default_nettype wire

// ---- bench/servo_drive_config_decode_checker.sv ----
// Port assertions for the configuration decode block.
// Assumes binding onto servo_drive_config_decode, one clock domain.
`timescale 1ns/10ps
`default_nettype none

module servo_cfg_checker
#(
	parameter int ERR_W = 32
)
(
	// Clock, reset and parameter port
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic param_wr_en,
	input wire logic [3:0] param_sel,
	input wire logic [15:0] param_wdata,
	input wire logic [15:0] param_rdata,
	input wire logic param_wr_err,
	// Status and drive outputs
	input wire logic fault_in,
	input wire logic drive_enable,
	input wire logic dynamic_braking,
	input wire logic plug_braking,
	input wire logic zero_clamp,
	input wire logic servo_disabled_state,
	input wire logic servo_alarm_output,
	input wire logic speed_limit_en,
	input wire logic current_limit_en
);
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	// Out of range writes must be refused with a pulse
	property p_bad_wr;
		param_wr_en && (param_sel > 4'hA || (param_sel == 4'h4 &&
			param_wdata > 16'h0005)) |=> param_wr_err;
	endproperty
	a_bad_wr: assert property (p_bad_wr)
		else $error("out of range write not refused");
	property p_good_wr;
		param_wr_en && param_sel == 4'h4 && param_wdata <= 16'h0005
			|=> !param_wr_err;
	endproperty
	a_good_wr: assert property (p_good_wr)
		else $error("legal write refused");
	property p_fmt_rb;
		param_wr_en && param_sel == 4'h8 && param_wdata <= 16'h0004 ##1
			param_sel == 4'h8 |=> param_rdata == $past(param_wdata, 2);
	endproperty
	a_fmt_rb: assert property (p_fmt_rb)
		else $error("format setting not read back");
	property p_alarm;
		fault_in |-> ##[1:2] servo_alarm_output;
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("alarm not raised by fault");
	property p_brake;
		dynamic_braking |-> !drive_enable && !plug_braking;
	endproperty
	a_brake: assert property (p_brake)
		else $error("dynamic braking while driven");
	property p_plug;
		plug_braking |-> drive_enable && !zero_clamp && !servo_disabled_state;
	endproperty
	a_plug: assert property (p_plug)
		else $error("plug braking without drive");
	property p_clamp;
		zero_clamp |-> drive_enable && !servo_disabled_state;
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("zero clamp without drive");
	// Stored at the write edge, enable register one edge later
	property p_spd;
		param_wr_en && param_sel == 4'h7 && param_wdata <= 16'h0001
			|=> ##1 speed_limit_en == $past(param_wdata[0], 2);
	endproperty
	a_spd: assert property (p_spd)
		else $error("speed limit enable not following setting");
	property p_cur;
		param_wr_en && param_sel == 4'hA && param_wdata <= 16'h0001
			|=> ##1 current_limit_en == $past(param_wdata[0], 2);
	endproperty
	a_cur: assert property (p_cur)
		else $error("current limit enable not following setting");
endmodule : servo_cfg_checker

bind servo_drive_config_decode servo_cfg_checker #(.ERR_W(ERR_W)) chk_i
	(.clk_sys, .rst_b, .param_wr_en, .param_sel, .param_wdata,
	.param_rdata, .param_wr_err, .fault_in, .drive_enable,
	.dynamic_braking, .plug_braking, .zero_clamp, .servo_disabled_state,
	.servo_alarm_output, .speed_limit_en, .current_limit_en);

`default_nettype wire

// ---- bench/ref_pulse_host.sv ----
// Host controller model driving the reference pulse lines.
// Assumes its tasks are called from the bench's main process.
`timescale 1ns/10ps
`default_nettype none

module ref_pulse_host
(
	// Clock
	input wire logic clk_sys,
	// Inversion the drive is set to
	input wire logic [1:0] pol,
	// Reference lines
	output logic pulse_input,
	output logic direction_input
);
	logic a = 1'b0;
	logic b = 1'b0;
	logic [1:0] q = 2'h0;

	// Wire levels follow the drive inversion so counts are not lost
	assign pulse_input = a ^ pol[1];
	assign direction_input = b ^ pol[0];

	task automatic gap_wait(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : gap_wait

	// Idle lines, phase back to zero
	task automatic park;
		@(posedge clk_sys);
		a <= 1'b0;
		b <= 1'b0;
		q <= 2'h0;
	endtask : park

	// One reference count; n cycles between changes sets the pace
	task automatic unit(input logic [2:0] fmt, input logic fwd,
		input int n);
		logic [1:0] nq;
		nq = q + (fwd ? 2'h1 : 2'h3);
		@(posedge clk_sys);
		if (fmt >= 3'h2)
		begin
			// Gray phase: only one line moves per quarter
			a <= nq[1] ^ nq[0];
			b <= nq[1];
			q <= nq;
		end
		else
		begin
			if (fmt == 3'h0)
				b <= fwd;
			gap_wait(n);
			if (fmt == 3'h0 || fwd)
				a <= 1'b1;
			else
				b <= 1'b1;
			gap_wait(n);
			a <= 1'b0;
			if (fmt == 3'h1)
				b <= 1'b0;
		end
		gap_wait(n);
	endtask : unit
endmodule : ref_pulse_host

`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the configuration decode block.
// Assumes the host model and checker bind are compiled alongside.
`timescale 1ns/10ps
`default_nettype none

module testbench;
	// ----------------
	// Signals
	// ----------------
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic param_wr_en = 1'b0;
	logic [3:0] param_sel = 4'h0;
	logic [15:0] param_wdata = 16'h0000;
	logic servo_on_in_b = 1'b0;
	logic fwd_travel_inhibit = 1'b0;
	logic rev_travel_inhibit = 1'b0;
	logic alarm_reset_in = 1'b0;
	logic power_loss_in = 1'b0;
	logic fault_in = 1'b0;
	logic motor_stopped = 1'b0;
	logic fb_step = 1'b0;
	logic fb_fwd = 1'b0;
	logic [1:0] pol = 2'h0;
	logic pulse_input, direction_input, param_wr_err, drive_enable;
	logic dynamic_braking, plug_braking, zero_clamp, servo_disabled_state;
	logic servo_alarm_output, ref_step, ref_ccw;
	logic speed_limit_en, current_limit_en;
	logic [15:0] param_rdata;
	logic [31:0] err_count;
	logic [4:0] flags;
	logic listen = 1'b0;
	logic [31:0] seed = 32'h4aaf_ff62;
	logic exp_q[$];
	logic [15:0] vals[11];
	int miscompares = 0;
	int checks = 0;

	// Drive, dyn brake, plug, clamp, disabled
	assign flags = {drive_enable, dynamic_braking, plug_braking, zero_clamp,
		servo_disabled_state};

	// 200 MHz clock
	always #2.5 clk_sys = ~clk_sys;

	servo_drive_config_decode uut (.clk_sys, .rst_b, .param_wr_en,
		.param_sel, .param_wdata, .param_rdata, .param_wr_err,
		.servo_on_in_b, .fwd_travel_inhibit, .rev_travel_inhibit,
		.alarm_reset_in, .power_loss_in, .pulse_input, .direction_input,
		.fault_in, .motor_stopped, .fb_step, .fb_fwd, .drive_enable,
		.dynamic_braking, .plug_braking, .zero_clamp, .servo_disabled_state,
		.servo_alarm_output, .ref_step, .ref_ccw, .err_count,
		.speed_limit_en, .current_limit_en);
	ref_pulse_host host (.clk_sys, .pol, .pulse_input, .direction_input);

	// ----------------
	// Tasks
	// ----------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk_val(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : chk_val

	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// Pins need two edges to land, outputs two more: eight is ample
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : settle

	task automatic wr(input logic [3:0] s, input logic [15:0] d);
		@(posedge clk_sys);
		param_wr_en <= 1'b1;
		param_sel <= s;
		param_wdata <= d;
		@(posedge clk_sys);
		param_wr_en <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [3:0] s, input logic [15:0] e);
		@(posedge clk_sys) param_sel <= s;
		settle(2);
		chk_val("param_rdata", e, param_rdata);
	endtask : rd

	// Each decoded step takes the oldest expected direction;
	// sampled mid-cycle, away from the edge that launches it
	always @(negedge clk_sys)
		if (listen && ref_step === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk_val("unexpected ref_step", 0, 1);
			else
				chk_val("ref_ccw", exp_q.pop_front(), ref_ccw);
		end

	// Hang guard
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		miscompares++;
		wrap_up();
	end

	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		int i;
		int k;
		logic [15:0] mx;
		logic [2:0] f;
		logic fw;
		logic r;
		logic [1:0] nq;
		repeat (4) @(posedge clk_sys);
		chk_val("disabled in reset", 1, servo_disabled_state);
		rst_b <= 1'b1;
		for (i = 0; i < 16; i++)
			rd(i[3:0], 16'h0000);
		$display("test reset_values done");
		for (i = 0; i < 11; i++)
		begin
			mx = (i == 4) ? 16'h0005 : (i == 8) ? 16'h0004 :
				(i == 9) ? 16'h0003 : 16'h0001;
			seed = lfsr(seed);
			vals[i] = seed[15:0] % (mx + 16'h0001);
			wr(i[3:0], vals[i]);
			chk_val("param_wr_err", 0, param_wr_err);
			wr(i[3:0], mx + 16'h0001);
			chk_val("param_wr_err", 1, param_wr_err);
			rd(i[3:0], vals[i]);
		end
		wr(4'hB, 16'h0000);
		chk_val("param_wr_err", 1, param_wr_err);
		chk_val("speed_limit_en", vals[7][0], speed_limit_en);
		chk_val("current_limit_en", vals[10][0], current_limit_en);
		$display("test parameters done");
		for (i = 0; i < 20; i++)
		begin
			// Pins glitch while settings change, so steps are ignored
			listen = 1'b0;
			f = 3'(i / 4);
			seed = lfsr(seed);
			r = seed[0];
			wr(4'h8, 16'(f));
			wr(4'h9, 16'(i % 4));
			wr(4'h6, 16'(r));
			@(posedge clk_sys) pol <= 2'(i % 4);
			host.park();
			settle(8);
			listen = 1'b1;
			for (k = 0; k < 6; k++)
			begin
				seed = lfsr(seed);
				fw = seed[1];
				nq = host.q + (fw ? 2'h1 : 2'h3);
				if (f < 3'h2 || f == 3'h4 || (f == 3'h3 && ^nq != ^host.q) ||
					(^nq && !(^host.q)))
					exp_q.push_back(fw ^ r);
				host.unit(f, fw, (k % 2 == 1) ? 7 : 2);
			end
			settle(8);
			chk_val("steps left", 0, exp_q.size());
		end
		$display("test reference_decode done");
		listen = 1'b0;
		for (i = 0; i < 4; i++)
			wr(i[3:0], 16'h0000);
		wr(4'h8, 16'h0000);
		wr(4'h9, 16'h0000);
		@(posedge clk_sys) pol <= 2'h0;
		host.park();
		for (i = 0; i < 6; i++)
		begin
			wr(4'h4, 16'(i));
			wr(4'h5, 16'(i >= 3));
			settle(8);
			chk_val("flags run", 5'h10, flags);
			@(posedge clk_sys)
			{fwd_travel_inhibit, rev_travel_inhibit} <= (i % 2) ? 2'h1 : 2'h2;
			settle(8);
			chk_val("flags travel", (i >= 2) ? 5'h14 : (i == 0) ? 5'h08 :
				5'h00, flags);
			@(posedge clk_sys) motor_stopped <= 1'b1;
			settle(8);
			chk_val("flags stopped", (i >= 4) ? 5'h12 : 5'h01, flags);
			@(posedge clk_sys)
			{fwd_travel_inhibit, rev_travel_inhibit, motor_stopped} <= 3'h0;
			host.unit(3'h0, 1'b1, 2);
			host.unit(3'h0, 1'b1, 2);
			// One forward feedback count takes one reference count back
			@(posedge clk_sys) {fb_step, fb_fwd} <= 2'h3;
			@(posedge clk_sys) fb_step <= 1'b0;
			@(posedge clk_sys) servo_on_in_b <= 1'b1;
			settle(8);
			chk_val("flags servo off", (i % 2) ? 5'h00 : 5'h08, flags);
			@(posedge clk_sys) motor_stopped <= 1'b1;
			settle(8);
			chk_val("err_count", (i < 3) ? 0 : i - 2, err_count);
			@(posedge clk_sys) {servo_on_in_b, motor_stopped} <= 2'h0;
		end
		wr(4'h0, 16'h0001);
		wr(4'h1, 16'h0001);
		wr(4'h2, 16'h0001);
		@(posedge clk_sys)
		{servo_on_in_b, fwd_travel_inhibit, rev_travel_inhibit} <= 3'h7;
		settle(8);
		chk_val("flags inputs unused", 5'h10, flags);
		$display("test stop_sequencing done");
		for (i = 0; i < 2; i++)
		begin
			wr(4'h3, 16'(i));
			@(posedge clk_sys) power_loss_in <= 1'b1;
			settle(8);
			chk_val("alarm on loss", 1, servo_alarm_output);
			@(posedge clk_sys) power_loss_in <= 1'b0;
			settle(8);
			chk_val("alarm on recovery", i, servo_alarm_output);
			@(posedge clk_sys) alarm_reset_in <= 1'b1;
			settle(8);
			chk_val("alarm after reset", 0, servo_alarm_output);
			@(posedge clk_sys) alarm_reset_in <= 1'b0;
		end
		@(posedge clk_sys) fault_in <= 1'b1;
		@(posedge clk_sys) fault_in <= 1'b0;
		settle(4);
		chk_val("alarm on fault", 1, servo_alarm_output);
		$display("test alarm done");
		wrap_up();
	end
endmodule : testbench

`default_nettype wire
